// ---- logic/cpms_regs.svh ----
// timing counts, field positions and reset values for the control port and status pins
`ifndef CPMS_REGS_SVH
`define CPMS_REGS_SVH
`define CPMS_I2C_ADDR_HI      5'h0F
`define CPMS_ADDR_BIT_ZERO    0
`define CPMS_ADDR_BIT_TWO     2
`define CPMS_DEEMPH_STATUS_OUT_5015        3'h4
`define CPMS_DEEMPH_STATUS_OUT_FIELD_LSB   2
`define CPMS_RATIO_RST        1'b0
`define CPMS_CLK_PERIOD_NS    4
`endif

// ---- logic/cpms_pkg.sv ----
// types for the control port mode and status pin block
package cpms_pkg;
  typedef enum logic [3:0] {
    CPMS_IDLE = 4'h1,
    CPMS_ADDR = 4'h2,
    CPMS_DATA = 4'h4,
    CPMS_ACK  = 4'h8
  } cpms_state_t;
endpackage

// ---- logic/cpms_mclk_div.sv ----
// recovered master clock divider running on the pll clock
`timescale 1ns/1ps
`default_nettype none
module cpms_mclk_div (
  input  wire logic pll_clk_i,
  input  wire logic nrst_i,
  input  wire logic ratio_128_i,
  output logic      mclk_o
);
  logic [1:0] div;
  logic       rsync1;
  logic       rsync2;
  logic       ratio_s1;
  logic       ratio_s2;

  // reset release and ratio select brought into the pll domain
  always_ff @(posedge pll_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsync1   <= 1'b0;
      rsync2   <= 1'b0;
      ratio_s1 <= 1'b0;
      ratio_s2 <= 1'b0;
    end else begin
      rsync1   <= 1'b1;
      rsync2   <= rsync1;
      ratio_s1 <= ratio_128_i;
      ratio_s2 <= ratio_s1;
    end
  end

  // pll clock is 512 fs; divide by 2 for 256 fs or by 4 for 128 fs
  always_ff @(posedge pll_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div <= 2'h0;
    end else if (rsync2) begin
      div <= div + 2'h1;
    end
  end

  // registered clock output
  always_ff @(posedge pll_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mclk_o <= 1'b0;
    end else begin
      mclk_o <= ratio_s2 ? div[1] : div[0];
    end
  end
endmodule
`default_nettype wire

// ---- logic/cpms_ctrl_pins.sv ----
// control port mode select, shared data pin, de-emphasis status and clock pin
//
// Function
// [RQ1] falling chip-select edge latches spi mode
// [RQ2] i2c address bit zero from chip-select pin
// [RQ3] spi transfers only while chip-select low
// [RQ4] i2c data pin pulled low or released
// [RQ5] spi read data driven on data-out
// [RQ6] de-emphasis low for 50/15 indication
// [RQ7] de-emphasis high for any other indication
// [RQ8] strapped de-emphasis level gives address bit two
// [RQ9] strap sampled at reset, held until reset
// [RQ10] reset low clears all state, low power
// [RQ11] host holds reset until clocks stable
// [RQ12] recovered clock output while pll used
// [RQ13] recovered clock 256 fs, optionally 128 fs
// [RQ14] pll bypass releases recovered clock pin
// [RQ15] channel select picks a or b status
`timescale 1ns/1ps
`default_nettype none
`include "cpms_regs.svh"
module cpms_ctrl_pins (
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       pll_clk_i,
  input  wire logic       sel_n_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       sdi_i,
  output logic            ctrl_serial_read_out_o,
  output logic            ctrl_serial_read_out_oe_o,
  input  wire logic [7:0] rd_data_i,
  output logic [7:0]      wr_data_o,
  output logic            wr_strobe_o,
  output logic            rd_strobe_o,
  output logic            spi_mode_o,
  output logic            slave_addr_bit_zero_o,
  output logic            slave_addr_bit_two_o,
  input  wire logic [2:0] cs_deemph_status_out_a_i,
  input  wire logic [2:0] cs_deemph_status_out_b_i,
  input  wire logic       status_channel_select_i,
  input  wire logic       deemph_pin_i,
  output logic            deemph_status_out_o,
  output logic            deemph_status_out_oe_o,
  input  wire logic       pll_bypass_i,
  input  wire logic       ratio_128_i,
  output logic            recovered_master_clk_o,
  output logic            recovered_master_clk_oe_o,
  output logic            low_power_o
);
  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic [3:0] s1;
  logic [3:0] s2;
  logic       sel_n_q;
  logic       scl_q;
  logic       sda_q;
  logic       rst_done;
  logic       rst_done2;
  logic       strap_taken;
  logic       sdi_s1;
  logic       sdi_s2;

  // spi data pin gets the same two stages as the clock it is read against
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end else begin
      sdi_s1 <= sdi_i;
      sdi_s2 <= sdi_s1;
    end
  end

  // two stages for every pin sampled by the core clock
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1 <= 4'hF;
      s2 <= 4'hF;
    end else begin
      s1 <= {sel_n_i, scl_i, sda_i, deemph_pin_i};
      s2 <= s1;
    end
  end

  // delayed copies for edge detection
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_n_q <= 1'b1;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end else begin
      sel_n_q <= s2[3];
      scl_q   <= s2[2];
      sda_q   <= s2[1];
    end
  end

  wire sel_fall = sel_n_q & ~s2[3];
  wire scl_rise = ~scl_q & s2[2];
  wire scl_fall = scl_q & ~s2[2];
  wire i2c_start = scl_q & s2[2] & sda_q & ~s2[1];
  wire i2c_stop  = scl_q & s2[2] & ~sda_q & s2[1];

  // --------------------------------------------------------------------
  // mode and address straps
  // --------------------------------------------------------------------
  // spi mode is sticky once a chip-select fall is seen
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spi_mode_o <= 1'b0; // see [RQ10]
    end else if (sel_fall) begin
      spi_mode_o <= 1'b1; // see [RQ1]
    end
  end

  // strap caught on the third edge after release, once the synchroniser
  // holds the pin level instead of its reset value, before the pin is driven
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_done             <= 1'b0;
      rst_done2            <= 1'b0;
      strap_taken          <= 1'b0;
      slave_addr_bit_two_o <= 1'b0;
    end else begin
      rst_done  <= 1'b1;
      rst_done2 <= rst_done;
      if (rst_done2 && !strap_taken) begin
        strap_taken          <= 1'b1;
        slave_addr_bit_two_o <= s2[0]; // see [RQ9] see [RQ8]
      end
    end
  end

  assign low_power_o = ~rst_done; // see [RQ10]

  // address bit zero follows the pin level in i2c operation
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slave_addr_bit_zero_o <= 1'b0;
    end else begin
      slave_addr_bit_zero_o <= s2[3]; // see [RQ2]
    end
  end

  // --------------------------------------------------------------------
  // serial engine
  // --------------------------------------------------------------------
  cpms_pkg::cpms_state_t state;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic       is_read;
  logic       addr_ok;
  logic       spi_first;
  logic       sda_low;

  wire [6:0] my_addr = {`CPMS_I2C_ADDR_HI, slave_addr_bit_two_o, slave_addr_bit_zero_o};
  wire selected = spi_mode_o & ~s2[3];

  // byte shifter and protocol state for both modes
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state       <= cpms_pkg::CPMS_IDLE;
      bit_cnt     <= 3'h0;
      shreg       <= 8'h00;
      tx          <= 8'h00;
      is_read     <= 1'b0;
      addr_ok     <= 1'b0;
      spi_first   <= 1'b1;
      sda_low     <= 1'b0;
      wr_data_o   <= 8'h00;
      wr_strobe_o <= 1'b0;
      rd_strobe_o <= 1'b0;
    end else begin
      wr_strobe_o <= 1'b0;
      rd_strobe_o <= 1'b0;
      if (spi_mode_o) begin
        if (!selected) begin
          state     <= cpms_pkg::CPMS_IDLE; // see [RQ3]
          bit_cnt   <= 3'h0;
          spi_first <= 1'b1;
          tx        <= rd_data_i;
        end else if (scl_rise) begin
          shreg   <= {shreg[6:0], sdi_s2};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            if (spi_first) begin
              spi_first <= 1'b0;
              is_read   <= sdi_s2;
            end else if (!is_read) begin
              wr_data_o   <= {shreg[6:0], sdi_s2};
              wr_strobe_o <= 1'b1;
            end else begin
              rd_strobe_o <= 1'b1;
            end
          end
        end else if (scl_fall && !spi_first) begin
          tx <= (bit_cnt == 3'h0) ? rd_data_i : {tx[6:0], 1'b0};
        end
      end else if (i2c_start) begin
        state   <= cpms_pkg::CPMS_ADDR;
        bit_cnt <= 3'h0;
        sda_low <= 1'b0;
      end else if (i2c_stop) begin
        state   <= cpms_pkg::CPMS_IDLE;
        sda_low <= 1'b0;
      end else begin
        unique case (state)
          cpms_pkg::CPMS_IDLE: begin
            sda_low <= 1'b0;
          end
          cpms_pkg::CPMS_ADDR, cpms_pkg::CPMS_DATA: begin
            if (scl_fall && is_read && state == cpms_pkg::CPMS_DATA) begin
              sda_low <= ~tx[7]; // see [RQ4]
              tx      <= {tx[6:0], 1'b0};
            end else if (scl_fall && state == cpms_pkg::CPMS_DATA) begin
              sda_low <= 1'b0;
            end
            if (scl_rise) begin
              shreg   <= {shreg[6:0], s2[1]};
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7) begin
                state <= cpms_pkg::CPMS_ACK;
                if (state == cpms_pkg::CPMS_ADDR) begin
                  addr_ok <= (shreg[6:0] == my_addr); // see [RQ2] see [RQ8]
                  is_read <= s2[1];
                  tx      <= rd_data_i;
                end else if (!is_read) begin
                  wr_data_o   <= {shreg[6:0], s2[1]};
                  wr_strobe_o <= 1'b1;
                end else begin
                  rd_strobe_o <= 1'b1;
                end
              end
            end
          end
          cpms_pkg::CPMS_ACK: begin
            if (scl_fall) begin
              sda_low <= addr_ok & ~(is_read & bit_cnt == 3'h0 & ~sda_low);
              if (!addr_ok) begin
                state <= cpms_pkg::CPMS_IDLE;
              end
            end else if (scl_rise) begin
              state   <= cpms_pkg::CPMS_DATA;
              if (is_read) begin
                tx <= rd_data_i;
              end
            end
          end
        endcase
      end
    end
  end

  // open drain in i2c: only pull low; spi drives read data while selected
  assign sda_o     = 1'b0; // see [RQ4]
  assign sda_oe_o  = ~spi_mode_o & sda_low;
  assign ctrl_serial_read_out_o    = tx[7]; // see [RQ5]
  assign ctrl_serial_read_out_oe_o = selected & ~spi_first & is_read; // see [RQ5] see [RQ3]

  // --------------------------------------------------------------------
  // de-emphasis status
  // --------------------------------------------------------------------
  // channel a or b emphasis field, low only for 50/15
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      deemph_status_out_o <= 1'b1;
    end else begin
      deemph_status_out_o <= ((status_channel_select_i ? cs_deemph_status_out_b_i : cs_deemph_status_out_a_i)
                              != `CPMS_DEEMPH_STATUS_OUT_5015); // see [RQ15] see [RQ6] see [RQ7]
    end
  end

  assign deemph_status_out_oe_o = strap_taken; // see [RQ9]

  // --------------------------------------------------------------------
  // recovered master clock
  // --------------------------------------------------------------------
  // pll domain divider; pin released when the pll is bypassed
  cpms_mclk_div cpms_mclk_div_i (
    .pll_clk_i   (pll_clk_i),
    .nrst_i      (nrst_i),
    .ratio_128_i (ratio_128_i),
    .mclk_o      (recovered_master_clk_o) // see [RQ12] see [RQ13]
  );

  assign recovered_master_clk_oe_o = rst_done & ~pll_bypass_i; // see [RQ14]
endmodule
`default_nettype wire

// ---- verification/cpms_ctrl_pins_checker.sv ----
// concurrent checks on the control port mode and status pins
`timescale 1ns/1ps
`default_nettype none
`include "cpms_regs.svh"
module cpms_ctrl_pins_checker (
  input wire logic       ref_clk_i,
  input wire logic       nrst_i,
  input wire logic       sel_n_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       spi_mode_o,
  input wire logic       ctrl_serial_read_out_oe_o,
  input wire logic       wr_strobe_o,
  input wire logic       rd_strobe_o,
  input wire logic [2:0] cs_deemph_status_out_a_i,
  input wire logic [2:0] cs_deemph_status_out_b_i,
  input wire logic       status_channel_select_i,
  input wire logic       deemph_status_out_o,
  input wire logic       deemph_status_out_oe_o,
  input wire logic       slave_addr_bit_two_o,
  input wire logic       low_power_o
);
  logic [2:0] deemph_status_out_sel;
  // emphasis field of the selected channel
  assign deemph_status_out_sel = status_channel_select_i ? cs_deemph_status_out_b_i : cs_deemph_status_out_a_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_sda_pull_only: assert property (sda_oe_o |-> !sda_o && !spi_mode_o)
    else $error("data pin driven high or in spi mode");
  a_mode_sticky: assert property (spi_mode_o |=> spi_mode_o)
    else $error("spi mode dropped");
  a_mode_entry: assert property ($fell(sel_n_i) |-> ##[1:4] spi_mode_o)
    else $error("select fall missed");
  a_ctrl_serial_read_out_spi: assert property (ctrl_serial_read_out_oe_o |-> spi_mode_o)
    else $error("read out driven outside spi");
  a_desel_quiet: assert property ((spi_mode_o && sel_n_i)[*8] |-> !wr_strobe_o && !rd_strobe_o)
    else $error("strobe while deselected");
  a_deemph_low: assert property ((deemph_status_out_oe_o && deemph_status_out_sel == `CPMS_DEEMPH_STATUS_OUT_5015)[*6]
    |-> !deemph_status_out_o)
    else $error("emphasis pin not low");
  a_deemph_high: assert property ((deemph_status_out_oe_o && deemph_status_out_sel != `CPMS_DEEMPH_STATUS_OUT_5015)[*6]
    |-> deemph_status_out_o)
    else $error("emphasis pin not high");
  a_strap_held: assert property (deemph_status_out_oe_o && $past(deemph_status_out_oe_o)
    |-> $stable(slave_addr_bit_two_o))
    else $error("strap bit changed");
  a_reset_state: assert property ($rose(nrst_i) |-> low_power_o && !spi_mode_o && !sda_oe_o)
    else $error("state not cleared by reset");
endmodule
`default_nettype wire

// ---- verification/cpms_host_model.sv ----
// host controller model driving the spi and i2c sides of the control port
`timescale 1ns/1ps
`default_nettype none
module cpms_host_model (
  input  wire logic ref_clk_i,
  input  wire logic ctrl_serial_read_out_i,
  input  wire logic sda_line_i,
  output var logic  sel_n_o,
  output var logic  scl_o,
  output var logic  sdi_o,
  output var logic  sda_o
);
  initial {sel_n_o, scl_o, sdi_o, sda_o} = 4'b1101;
  // chip-select level, then settle time before any clock
  task automatic select(input logic on);
    @(posedge ref_clk_i) sel_n_o <= ~on;
    repeat (4) @(posedge ref_clk_i);
  endtask
  // one byte msb first, clock phases of five cycles each
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge ref_clk_i) scl_o <= 1'b0;
      sdi_o <= sel_n_o ? ~sdi_o : tx[i]; // deselected line wanders
      repeat (5) @(posedge ref_clk_i);
      scl_o <= 1'b1;
      rx[i] = ctrl_serial_read_out_i;
      repeat (4) @(posedge ref_clk_i);
    end
  endtask
  // i2c start, address byte, ninth clock for the ack, then stop
  task automatic i2c_addr(input logic [7:0] b, output logic ack);
    @(posedge ref_clk_i) sda_o <= 1'b0; // start while clock high
    repeat (5) @(posedge ref_clk_i);
    for (int i = 8; i >= 0; i--) begin
      @(posedge ref_clk_i) scl_o <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      sda_o <= (i == 0) ? 1'b1 : b[i - 1];
      repeat (3) @(posedge ref_clk_i);
      scl_o <= 1'b1;
      ack = !sda_line_i;
      repeat (4) @(posedge ref_clk_i);
    end
    @(posedge ref_clk_i) scl_o <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    sda_o <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    scl_o <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    sda_o <= 1'b1; // stop
    repeat (5) @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// ---- verification/cpms_ctrl_pins_tb.sv ----
// self-checking bench for the control port mode and status pins
`timescale 1ns/1ps
`default_nettype none
`include "cpms_regs.svh"
module cpms_ctrl_pins_tb;
  logic ref_clk_i, nrst_i, pll_clk_i, sel_n_i, scl_i, sda_i, sda_o, sda_oe_o, sdi_i, strap;
  logic ctrl_serial_read_out_o, ctrl_serial_read_out_oe_o, wr_strobe_o, rd_strobe_o;
  logic spi_mode_o, slave_addr_bit_zero_o, slave_addr_bit_two_o, deemph_pin_i, ratio_128_i;
  logic status_channel_select_i, deemph_status_out_o, deemph_status_out_oe_o, pll_bypass_i;
  logic recovered_master_clk_o, recovered_master_clk_oe_o, low_power_o, host_sda, ack;
  logic [7:0] rd_data_i, wr_data_o, rx;
  logic [2:0] cs_deemph_status_out_a_i, cs_deemph_status_out_b_i;
  int   err_count, tests_run, n_wr, n_rd, n_clk;
  cpms_ctrl_pins cpms_ctrl_pins_i (.*);
  cpms_host_model cpms_host_model_i (.ref_clk_i, .ctrl_serial_read_out_i(ctrl_serial_read_out_o),
    .sda_line_i(sda_i), .sel_n_o(sel_n_i), .scl_o(scl_i), .sdi_o(sdi_i), .sda_o(host_sda));
  // pull-up on the data pin, strap resistor on the emphasis pin
  assign sda_i = host_sda & !sda_oe_o;
  assign deemph_pin_i = deemph_status_out_oe_o ? deemph_status_out_o : strap;
  // clocks, the pll one unrelated in phase
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    pll_clk_i = 1'b0;
    #37;
    forever #80 pll_clk_i = ~pll_clk_i;
  end
  // strobe and recovered clock counters
  always @(posedge ref_clk_i) begin
    n_wr <= n_wr + int'(wr_strobe_o);
    n_rd <= n_rd + int'(rd_strobe_o);
  end
  always @(posedge recovered_master_clk_o) n_clk <= n_clk + 1;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // reset with a given strap level on the emphasis pin
  task automatic do_reset(input logic lvl);
    nrst_i <= 1'b0;
    strap <= lvl;
    repeat (4) @(posedge ref_clk_i);
    check(low_power_o, 1'b1);
    check(deemph_status_out_oe_o, 1'b0);
    repeat (2) @(posedge pll_clk_i);
    @(posedge ref_clk_i) nrst_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    check(slave_addr_bit_two_o, lvl);
    check(spi_mode_o, 1'b0);
  endtask
  initial begin
    #60000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    {rd_data_i, cs_deemph_status_out_a_i, cs_deemph_status_out_b_i} <= 14'h2940;
    {status_channel_select_i, pll_bypass_i, ratio_128_i} <= 3'h0;
    do_reset(1'b0);
    check(slave_addr_bit_zero_o, 1'b1);
    check(sda_oe_o, 1'b0);
    $display("reset test done");
    // every emphasis code on both channels
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk_i) cs_deemph_status_out_a_i <= i[2:0];
      cs_deemph_status_out_b_i <= ~i[2:0];
      status_channel_select_i <= i[3];
      repeat (8) @(posedge ref_clk_i);
      check(deemph_status_out_o, (i[3] ? ~i[2:0] : i[2:0]) != `CPMS_DEEMPH_STATUS_OUT_5015);
    end
    $display("emphasis test done");
    // spi write, a byte while deselected, then a read
    cpms_host_model_i.select(1'b1);
    check(spi_mode_o, 1'b1);
    cpms_host_model_i.xfer(8'h10, rx);
    cpms_host_model_i.xfer(8'h3C, rx);
    cpms_host_model_i.select(1'b0);
    cpms_host_model_i.xfer(8'hC3, rx);
    repeat (8) @(posedge ref_clk_i);
    check(8'(n_wr), 8'h01);
    check(wr_data_o, 8'h3C);
    cpms_host_model_i.select(1'b1);
    cpms_host_model_i.xfer(8'h11, rx);
    cpms_host_model_i.xfer(8'h00, rx);
    check(rx, 8'hA5);
    cpms_host_model_i.select(1'b0);
    check(8'(n_rd), 8'h01);
    $display("spi test done");
    // recovered clock rate at both ratios, then bypass
    for (int r = 0; r < 2; r++) begin
      @(posedge ref_clk_i) ratio_128_i <= r[0];
      repeat (8) @(negedge pll_clk_i);
      n_clk = 0;
      repeat (32) @(negedge pll_clk_i);
      check(8'(n_clk), r[0] ? 8'h08 : 8'h10);
    end
    @(posedge ref_clk_i) pll_bypass_i <= 1'b1;
    repeat (4) @(negedge pll_clk_i);
    check(recovered_master_clk_oe_o, 1'b0);
    @(posedge ref_clk_i) pll_bypass_i <= 1'b0;
    repeat (4) @(negedge pll_clk_i);
    check(recovered_master_clk_oe_o, 1'b1);
    $display("clock test done");
    @(posedge ref_clk_i);
    do_reset(1'b1);
    $display("second reset test done");
    // i2c address match acks, a mismatch in bit zero does not
    cpms_host_model_i.i2c_addr({`CPMS_I2C_ADDR_HI, 2'b11, 1'b0}, ack);
    check(8'(ack), 8'h01);
    cpms_host_model_i.i2c_addr({`CPMS_I2C_ADDR_HI, 2'b10, 1'b0}, ack);
    check(8'(ack), 8'h00);
    $display("i2c test done");
    tally_and_finish();
  end
endmodule
bind cpms_ctrl_pins cpms_ctrl_pins_checker cpms_ctrl_pins_checker_i (.*);
`default_nettype wire
